// ===== hw/rcf_cfg.svh
// register offsets, bit positions and reset values of the reset-cause flag bank
`ifndef RCF_CFG_SVH
`define RCF_CFG_SVH

// ============================================================
// byte offsets on the register bus
`define RCF_OFF_MAIN        12'h000
`define RCF_OFF_EXTRA       12'h004
`define RCF_OFF_SCRATCH0    12'h008
`define RCF_OFF_SCRATCH3    12'h014
`define RCF_OFF_STATUS      12'h018
`define RCF_OFF_CONTROL     12'h01C
`define RCF_ADDR_W          12
`define RCF_SCRATCH_N       4

// ============================================================
// bit positions in the main flag register
`define RCF_B_STK_OVF       7
`define RCF_B_STK_UNF       6
`define RCF_B_WDT_WIN       5
`define RCF_B_WDT_TMO       4
`define RCF_B_EXT_PIN       3
`define RCF_B_RST_INSTR     2
`define RCF_B_POWER_ON      1
`define RCF_B_MAIN_BOR      0

// bit positions in the extra flag register
`define RCF_B_MEM_VIOL      1
`define RCF_B_BAT_BOR       0
`define RCF_EXTRA_MASK      8'h03

// ============================================================
// values after power-on / brown-out and at loss of both supplies
`define RCF_MAIN_BOR_BITS   6'h0F
`define RCF_MAIN_RESET      8'h3C
`define RCF_EXTRA_RESET     8'h02
`define RCF_SCRATCH_RESET   8'h00
`define RCF_CONTROL_RESET   8'h01

// control and status bit positions
`define RCF_B_CTL_STK_EN    0
`define RCF_B_ST_ON_BAT     0
`define RCF_B_ST_CORE_HOLD  1
`define RCF_B_ST_CAL_HOLD   2
`define RCF_B_ST_VDD_LOW    3
`define RCF_B_ST_VBAT_LOW   4

`endif

// ===== hw/rcf_pkg.sv
// types shared by the reset-cause flag bank
package rcf_pkg;

    // ============================================================
    // reset-cause event pulses from the reset controller, one cycle each
    typedef struct packed {
        logic por;            // power-on reset
        logic stack_overflow;
        logic stack_underflow;
        logic wdt_window;     // watchdog clear outside or without armed window
        logic wdt_timeout;
        logic ext_pin;        // external reset pin
        logic reset_instr;    // reset instruction executed
        logic mem_violation;
    } rcf_cause_t;

    // supply comparator levels
    typedef struct packed {
        logic vdd_below_bor;
        logic vbat_below_bor;
        logic vdd_below_vbat;
    } rcf_supply_t;

    // supply-state summary
    typedef enum logic [1:0] {
        RCF_SUP_ALL_OK,
        RCF_SUP_MAIN_LOST,
        RCF_SUP_BOTH_LOST
    } rcf_sup_state_t;

endpackage : rcf_pkg

// ===== hw/rcf_reset_cause_bank.sv
// reset-cause flag bank with battery-backed scratch registers on an apb slave
//
// Summary of operation
// - each reset except power-on and brown-out updates only the flag of its own cause; others keep value
// - hardware returns flags to inactive only at power-on/brown-out; otherwise only firmware writes do
// - firmware may write flags active; stored, but no reset results
// - both flag registers keep contents while either supply is powered
// - main bit 7 stack overflow: set on overflow reset, 0 at power-on/brown-out
// - main bit 6 stack underflow: set on underflow reset, 0 at power-on/brown-out
// - bit 5 window violation, active low; 1 after power-on and brown-out
// - bit 4 watchdog timeout, active low; 1 after power-on and brown-out
// - bit 3 external pin reset, active low; 1 after power-on and brown-out
// - bit 2 reset instruction, active low; 1 after power-on and brown-out
// - bit 1 power-on, active low; cleared on power-on, firmware rewrites 1
// - bit 0 main brown-out, active low; cleared on brown-out, firmware sets
// - extra bit 1 memory violation, active low; bits 7..2 read zero
// - extra bit 0 battery brown-out: 0 after battery brown-out reset
// - calendar and oscillator use battery whenever main supply is below it
// - with main supply good, both brown-out flags stay unchanged
// - main low, battery good: hold core in reset, clear main brown-out flag
// - both low: hold everything in reset, clear both brown-out flags
// - scratch registers keep last written value while either supply valid
// - stack events reset and flag only when stack reset enable is set
`timescale 1ns/1ps
`include "rcf_cfg.svh"

// ============================================================
// register map, one byte per word

// 0x00 main cause flags
// 0x04 extra cause flags

// 0x08 to 0x14 scratch 0 to 3
// 0x18 status, read only
// 0x1C control

// bits 31..8 of each word read 0
// only the low byte lane writes
// paddr bits above 11 alias

// ============================================================
// flag bits, msb first

// 7 stack overflow, active high
// 6 stack underflow, active high

// 5 window violation, active low
// 4 watchdog timeout, active low

// 3 external pin, active low
// 2 reset instruction, active low

// 1 power-on, active low
// 0 main brown-out, active low

// all supplies lost: 0x3C

// extra 1: memory violation, active low
// extra 0: battery brown-out, active low
// extra 7..2 read 0

// ============================================================
// status and control

// status 0: calendar on battery
// status 1: core held in reset
// status 2: calendar held in reset
// status 3: main supply low
// status 4: battery low

// control 0: stack reset enable
// it stands in for a fuse and
// keeps its value over core resets

// ============================================================
// notes for firmware

// flags never go back to their
// inactive value by themselves

// rewrite power-on and brown-out
// to 1 after each restart

// writing a flag active stores
// it; no reset follows

// an event and a write in one
// cycle: the event wins per bit

// several causes in one cycle
// each move only their own bit;
// power-on and brown-out win

// stack causes count only while
// the enable bit is set

// brown-out is a level: flags are
// forced every cycle it lasts

// a write to status is refused
// with pslverr and ignored

// unmapped or misaligned words
// answer pslverr and read 0

// a cleared low strobe completes
// the write but changes nothing

// presetn stands for the loss of
// both supplies; nothing else
// resets flags or scratch

// ============================================================
// bus timing

// c0 setup: psel, no penable
// c1 access: answer registered
// c2 pready high; the edge at
// its end commits a write
// c3 master releases the bus

// trade-off: the registered
// answer costs a wait state but
// keeps outputs on flip-flops

// ============================================================
// reset holds

// the core hold rises with a cause
// and falls one edge after it, so
// the core restarts on settled flags

// the calendar hold waits for
// the battery to fail as well

// a main supply below the battery
// but still valid also switches
// the calendar over

module rcf_reset_cause_bank (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    input  wire rcf_pkg::rcf_cause_t    cause,
    input  wire rcf_pkg::rcf_supply_t   supply,
    output logic                        core_reset_hold,
    output logic                        calendar_reset_hold,
    output logic                        calendar_on_battery
);

    // ============================================================
    // state
    logic [7:0]               flags_main_reg;
    logic [7:0]               flags_main_next;
    logic [7:0]               flags_extra_reg;
    logic [7:0]               flags_extra_next;
    logic [7:0]               scratch_reg [`RCF_SCRATCH_N];
    logic [7:0]               control_reg;
    logic                     pready_reg;
    logic [31:0]              prdata_reg;
    logic                     pslverr_reg;
    logic                     core_hold_reg;
    logic                     cal_hold_reg;
    logic                     on_battery_reg;
    rcf_pkg::rcf_sup_state_t  sup_state;
    logic                     stack_en;
    logic                     stk_ovf_evt;
    logic                     stk_unf_evt;
    logic                     any_cause;
    logic                     wr_commit;
    logic [`RCF_ADDR_W-1:0]   addr;
    logic                     addr_hit;
    logic [31:0]              rd_value;
    logic [7:0]               status_value;

    // ============================================================
    // supply decode
    always_comb begin
        if (supply.vdd_below_bor && supply.vbat_below_bor) begin
            sup_state = rcf_pkg::RCF_SUP_BOTH_LOST;
        end else if (supply.vdd_below_bor) begin
            sup_state = rcf_pkg::RCF_SUP_MAIN_LOST;
        end else begin
            sup_state = rcf_pkg::RCF_SUP_ALL_OK;
        end
    end

    // stack events only count as a reset cause when enabled
    assign stack_en    = control_reg[`RCF_B_CTL_STK_EN];
    assign stk_ovf_evt = cause.stack_overflow && stack_en;
    assign stk_unf_evt = cause.stack_underflow && stack_en;
    assign any_cause   = cause.por || stk_ovf_evt || stk_unf_evt || cause.wdt_window
                      || cause.wdt_timeout || cause.ext_pin || cause.reset_instr
                      || cause.mem_violation;

    // ============================================================
    // apb decode: one wait state, write commits on the edge that sees pready
    assign addr      = paddr[`RCF_ADDR_W-1:0];
    assign wr_commit = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign addr_hit  = (addr[1:0] == 2'h0) && (addr <= `RCF_OFF_CONTROL);

    assign status_value = {3'h0,
                           supply.vbat_below_bor,
                           supply.vdd_below_bor,
                           cal_hold_reg,
                           core_hold_reg,
                           on_battery_reg};

    // read multiplexer, narrow registers sit in the low byte
    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (addr)
            `RCF_OFF_MAIN:    rd_value = {24'h00_0000, flags_main_reg};
            `RCF_OFF_EXTRA:   rd_value = {24'h00_0000, flags_extra_reg & `RCF_EXTRA_MASK};
            `RCF_OFF_STATUS:  rd_value = {24'h00_0000, status_value};
            `RCF_OFF_CONTROL: rd_value = {24'h00_0000, control_reg};
            default: begin
                if (addr_hit) begin
                    rd_value = {24'h00_0000, scratch_reg[2'(addr[4:2] - 3'h2)]};
                end
            end
        endcase
    end

    // ============================================================
    // flag next-state: firmware write first, hardware events override it
    always_comb begin
        flags_main_next  = flags_main_reg;
        flags_extra_next = flags_extra_reg;
        // any value may be written, active included, with no reset resulting
        if (wr_commit && pstrb[0] && addr == `RCF_OFF_MAIN) begin
            flags_main_next = pwdata[7:0];
        end
        if (wr_commit && pstrb[0] && addr == `RCF_OFF_EXTRA) begin
            flags_extra_next = pwdata[7:0] & `RCF_EXTRA_MASK;
        end
        // each cause touches its own bit only; later lines win
        if (stk_ovf_evt) begin
            flags_main_next[`RCF_B_STK_OVF] = 1'b1;
        end
        if (stk_unf_evt) begin
            flags_main_next[`RCF_B_STK_UNF] = 1'b1;
        end
        if (cause.wdt_window) begin
            flags_main_next[`RCF_B_WDT_WIN] = 1'b0;
        end
        if (cause.wdt_timeout) begin
            flags_main_next[`RCF_B_WDT_TMO] = 1'b0;
        end
        if (cause.ext_pin) begin
            flags_main_next[`RCF_B_EXT_PIN] = 1'b0;
        end
        if (cause.reset_instr) begin
            flags_main_next[`RCF_B_RST_INSTR] = 1'b0;
        end
        if (cause.mem_violation) begin
            flags_extra_next[`RCF_B_MEM_VIOL] = 1'b0;
        end
        // power-on: reset bits 7..2, clear power-on flag, brown-out flag kept
        if (cause.por) begin
            flags_main_next[7:2]              = `RCF_MAIN_BOR_BITS;
            flags_main_next[`RCF_B_POWER_ON]  = 1'b0;
            flags_extra_next[`RCF_B_MEM_VIOL] = 1'b1;
        end
        // brown-out held as a level while the main supply is low
        unique case (sup_state)
            rcf_pkg::RCF_SUP_MAIN_LOST: begin
                flags_main_next[7:2]              = `RCF_MAIN_BOR_BITS;
                flags_main_next[`RCF_B_MAIN_BOR]  = 1'b0;
                flags_extra_next[`RCF_B_MEM_VIOL] = 1'b1;
            end
            rcf_pkg::RCF_SUP_BOTH_LOST: begin
                flags_main_next[7:2]              = `RCF_MAIN_BOR_BITS;
                flags_main_next[`RCF_B_MAIN_BOR]  = 1'b0;
                flags_extra_next[`RCF_B_MEM_VIOL] = 1'b1;
                flags_extra_next[`RCF_B_BAT_BOR]  = 1'b0;
            end
            default: begin
                flags_main_next = flags_main_next;
            end
        endcase
    end

    // ============================================================
    // flag registers: only loss of both supplies (presetn) reinitialises them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_main_reg  <= `RCF_MAIN_RESET;
            flags_extra_reg <= `RCF_EXTRA_RESET;
        end else begin
            flags_main_reg  <= flags_main_next;
            flags_extra_reg <= flags_extra_next;
        end
    end

    // battery-domain scratch registers, one per entry
    genvar gi;
    generate
        for (gi = 0; gi < `RCF_SCRATCH_N; gi++) begin : g_scratch
            localparam logic [`RCF_ADDR_W-1:0] OFF =
                `RCF_OFF_SCRATCH0 + `RCF_ADDR_W'(4 * gi);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    scratch_reg[gi] <= `RCF_SCRATCH_RESET;
                end else if (wr_commit && pstrb[0] && addr == OFF) begin
                    scratch_reg[gi] <= pwdata[7:0];
                end
            end
        end
    endgenerate

    // control register; survives core resets like the flags do
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= `RCF_CONTROL_RESET;
        end else if (wr_commit && pstrb[0] && addr == `RCF_OFF_CONTROL) begin
            control_reg <= {7'h00, pwdata[`RCF_B_CTL_STK_EN]};
        end
    end

    // ============================================================
    // apb answer: pready one cycle into the access phase, data and error with it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (psel && penable && !pready_reg) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= !addr_hit || (pwrite && addr == `RCF_OFF_STATUS);
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_value;
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end
    end

    // ============================================================
    // reset holds: the hold rises with the cause and drops a cycle after the
    // flags have settled, so firmware never sees a stale flag after restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_hold_reg <= 1'b1;
            cal_hold_reg  <= 1'b1;
        end else begin
            core_hold_reg <= any_cause || supply.vdd_below_bor;
            cal_hold_reg  <= (sup_state == rcf_pkg::RCF_SUP_BOTH_LOST);
        end
    end

    // calendar supply switch follows the comparators even with main valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_battery_reg <= 1'b0;
        end else begin
            on_battery_reg <= supply.vdd_below_vbat || supply.vdd_below_bor;
        end
    end

    assign pready              = pready_reg;
    assign prdata              = prdata_reg;
    assign pslverr             = pslverr_reg;
    assign core_reset_hold     = core_hold_reg;
    assign calendar_reset_hold = cal_hold_reg;
    assign calendar_on_battery = on_battery_reg;

endmodule : rcf_reset_cause_bank

// ===== tb/rcf_bank_props.sv
// concurrent checks on the ports of the reset-cause flag bank
`timescale 1ns/1ps
module rcf_bank_props (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [31:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic                  pready,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    input wire rcf_pkg::rcf_cause_t   cause,
    input wire rcf_pkg::rcf_supply_t  supply,
    input wire logic                  core_reset_hold,
    input wire logic                  calendar_reset_hold,
    input wire logic                  calendar_on_battery
);
    default clocking dck @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================================
    // bus timing
    a_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_qual: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_unmapped_err: assert property (psel && penable && !pready &&
        (paddr[11:0] > 12'h01C || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unmapped access not refused");

    // ==========================================================
    // reset holds and supply switch; stack events left out, they depend on control; window and memory violation causes not checked
    a_cause_hold: assert property ((cause.por || cause.wdt_timeout || cause.ext_pin
        || cause.reset_instr || supply.vdd_below_bor) |=> core_reset_hold)
        else $error("core hold missing");
    a_hold_drop: assert property (presetn && cause == 8'h00 && !supply.vdd_below_bor
        |=> !core_reset_hold) else $error("core hold not released");
    a_cal_batt: assert property (1'h1 |=>
        calendar_on_battery == $past(supply.vdd_below_vbat || supply.vdd_below_bor))
        else $error("calendar supply switch wrong");
    a_cal_hold: assert property (supply.vdd_below_bor && supply.vbat_below_bor
        |=> calendar_reset_hold) else $error("calendar hold missing");
    a_cal_run: assert property (presetn && !supply.vbat_below_bor
        |=> !calendar_reset_hold) else $error("calendar held with battery good");

    c_write: cover property (psel && penable && pready && pwrite);
    c_por: cover property (cause.por);
    c_both_low: cover property (supply.vdd_below_bor && supply.vbat_below_bor);
endmodule : rcf_bank_props

bind rcf_reset_cause_bank rcf_bank_props rcf_bank_props_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr), .cause(cause),
    .supply(supply), .core_reset_hold(core_reset_hold),
    .calendar_reset_hold(calendar_reset_hold), .calendar_on_battery(calendar_on_battery));

// ===== tb/tb_top.sv
// self-checking bench for the reset-cause flag bank
`timescale 1ns/1ps
`include "rcf_cfg.svh"
module tb_top;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0]          paddr, pwdata, prdata;
    logic [3:0]           pstrb;
    logic                 core_reset_hold, calendar_reset_hold, calendar_on_battery;
    rcf_pkg::rcf_cause_t  cause;
    rcf_pkg::rcf_supply_t supply;
    logic [7:0]           rd, m, sv [4];
    logic [1:0]           e;
    logic [9:0]           x;
    int                   err_count, check_count;

    rcf_reset_cause_bank rcf_reset_cause_bank_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .cause(cause), .supply(supply),
        .core_reset_hold(core_reset_hold), .calendar_reset_hold(calendar_reset_hold),
        .calendar_on_battery(calendar_on_battery));

    // ==========================================================
    // clock, 100 ns period
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input string n, input logic [7:0] ex, input logic [7:0] got);
        check_count++;
        if (got !== ex) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, ex, got);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test

    // one apb transfer; hw is driven on the cause input through the access phase
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s, input logic [7:0] hw);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {20'h0, a};
        pstrb <= s;
        pwdata <= {24'($urandom), d};
        @(posedge pclk);
        penable <= 1'h1;
        cause <= rcf_pkg::rcf_cause_t'(hw);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        rd = prdata[7:0];
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        cause <= rcf_pkg::rcf_cause_t'(8'h00);
        if (n >= 16) begin
            err_count++;
            finish_test();
        end
    endtask : apb

    task automatic rd_chk(input string n, input logic [11:0] a, input logic [7:0] ex);
        apb(1'h0, a, 8'h00, 4'hF, 8'h00);
        chk(n, ex, rd);
    endtask : rd_chk

    task automatic scr_chk;
        for (int i = 0; i < 4; i++) rd_chk("scratch", `RCF_OFF_SCRATCH0 + 12'(4 * i), sv[i]);
    endtask : scr_chk

    // two edges of an event; the hold outputs are looked at after the first
    task automatic pulse(input logic [7:0] c, input logic [2:0] s, input logic hx);
        @(posedge pclk);
        cause <= rcf_pkg::rcf_cause_t'(c);
        supply <= rcf_pkg::rcf_supply_t'(s);
        @(posedge pclk);
        #1;
        chk("core_hold", {7'h0, hx}, {7'h0, core_reset_hold});
        chk("cal_hold", {7'h0, s[2] & s[1]}, {7'h0, calendar_reset_hold});
        chk("on_battery", {7'h0, s[2] | s[0]}, {7'h0, calendar_on_battery});
        @(posedge pclk);
        cause <= rcf_pkg::rcf_cause_t'(8'h00);
        supply <= rcf_pkg::rcf_supply_t'(3'h0);
    endtask : pulse

    // expected {main, extra[1:0]} after an event; k is the stack reset enable
    function automatic logic [9:0] fx(input logic [7:0] c, input logic [2:0] s, input logic k,
                                      input logic [7:0] mi, input logic [1:0] ei);
        logic [7:0] r;
        logic [1:0] f;
        r = mi;
        f = ei;
        if (c[7]) r = {6'h0F, 1'h0, r[0]};
        if (c[7]) f[1] = 1'h1;
        if (c[6] & k) r[7] = 1'h1;
        if (c[5] & k) r[6] = 1'h1;
        if (c[4]) r[5] = 1'h0;
        if (c[3]) r[4] = 1'h0;
        if (c[2]) r[3] = 1'h0;
        if (c[1]) r[2] = 1'h0;
        if (c[0]) f[1] = 1'h0;
        if (s[2]) r = {6'h0F, r[1], 1'h0};
        if (s[2]) f[1] = 1'h1;
        if (s[2] & s[1]) f[0] = 1'h0;
        return {r, f};
    endfunction : fx

    // loads random flag values, fires an event, reads both flag registers back
    task automatic event_test(input logic [7:0] c, input logic [2:0] s, input logic k,
                              input logic hx);
        m = 8'($urandom);
        e = 2'($urandom);
        apb(1'h1, `RCF_OFF_MAIN, m, 4'hF, 8'h00);
        apb(1'h1, `RCF_OFF_EXTRA, {6'h0, e}, 4'hF, 8'h00);
        pulse(c, s, hx);
        x = fx(c, s, k, m, e);
        rd_chk("main", `RCF_OFF_MAIN, x[9:2]);
        rd_chk("extra", `RCF_OFF_EXTRA, {6'h0, x[1:0]});
    endtask : event_test

    // ==========================================================
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        cause = rcf_pkg::rcf_cause_t'(8'h00);
        supply = rcf_pkg::rcf_supply_t'(3'h0);
        err_count = 0;
        check_count = 0;
        void'($urandom(32'h63D0CD2D));
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        rd_chk("main", `RCF_OFF_MAIN, 8'h3C);
        rd_chk("extra", `RCF_OFF_EXTRA, 8'h02);
        rd_chk("control", `RCF_OFF_CONTROL, 8'h01);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            sv[i] = 8'($urandom);
            apb(1'h1, `RCF_OFF_SCRATCH0 + 12'(4 * i), sv[i], 4'hF, 8'h00);
        end
        apb(1'h1, `RCF_OFF_SCRATCH0, ~sv[0], 4'hE, 8'h00); // low strobe off: no change
        scr_chk();
        apb(1'h1, `RCF_OFF_MAIN, 8'hC0, 4'hF, 8'h00);
        #1;
        chk("core_hold", 8'h00, {7'h0, core_reset_hold});
        rd_chk("main", `RCF_OFF_MAIN, 8'hC0);
        apb(1'h1, `RCF_OFF_EXTRA, 8'hFC, 4'hF, 8'h00);
        rd_chk("extra", `RCF_OFF_EXTRA, 8'h00);
        apb(1'h1, `RCF_OFF_MAIN, 8'hFF, 4'hF, 8'h08); // timeout event meets the write
        rd_chk("main", `RCF_OFF_MAIN, 8'hEF);
        $display("test firmware writes done");
        // every cause, with stack resets enabled and then disabled
        for (int k = 1; k >= 0; k--) begin
            apb(1'h1, `RCF_OFF_CONTROL, 8'(k), 4'hF, 8'h00);
            for (int b = 0; b < 8; b++) begin
                event_test(8'(1 << b), 3'h0, k[0], k[0] || (b != 5 && b != 6));
            end
        end
        $display("test reset causes done");
        for (int s = 0; s < 8; s++) event_test(8'h00, 3'(s), 1'h0, s[2]);
        scr_chk();
        $display("test supply states done");
        for (int j = 0; j < 3; j++) begin
            apb(1'h0, j == 0 ? 12'h020 : j == 1 ? 12'h002 : 12'hFFC, 8'h00, 4'hF, 8'h00);
            chk("rd_err", 8'h01, {7'h0, er});
            chk("rd_data", 8'h00, rd);
        end
        apb(1'h1, `RCF_OFF_STATUS, 8'hFF, 4'hF, 8'h00);
        chk("wr_err", 8'h01, {7'h0, er});
        rd_chk("status", `RCF_OFF_STATUS, 8'h00);
        $display("test refusals done");
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rd_chk("main", `RCF_OFF_MAIN, 8'h3C);
        for (int i = 0; i < 4; i++) sv[i] = 8'h00;
        scr_chk();
        $display("test second reset done");
        finish_test();
    end
endmodule : tb_top
